// File: qbsr_pkg.sv
// Purpose : Shared constants for the burst-of-four DDR static memory link
// Assumes : Both ends compile against this package
// Notes   : Widths are the defaults of the module parameters
`default_nettype none

package qbsr_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 19;
    localparam int DATA_W  = 36;
    localparam int LANES   = 4;
    localparam int BURST   = 4;
    localparam int BEAT_W  = 2;

    // ----------------------------------------------------------------
    // Address slots on the true clock rising edge
    // ----------------------------------------------------------------
    localparam logic SLOT_RD = 1'h0;
    localparam logic SLOT_WR = 1'h1;

    // ----------------------------------------------------------------
    // Controller phase counter: one phase per system clock cycle
    // ----------------------------------------------------------------
    localparam logic [1:0] PH_RD_PREP = 2'h3;
    localparam logic [1:0] PH_WR_PREP = 2'h1;
    localparam logic [1:0] PH_LAST    = 2'h3;
    localparam logic [1:0] PH_RESET   = 2'h0;

    // ----------------------------------------------------------------
    // Read return: issue history depth and first capture position
    // ----------------------------------------------------------------
    localparam int         HIST_W     = 6;
    localparam logic [2:0] CAP_DLL_OFF = 3'h1;
    localparam logic [2:0] CAP_DLL_ON  = 3'h2;

endpackage

`default_nettype wire

// File: qbsr_link_if.sv
// Purpose : Pin-level link between memory controller and memory device
// Assumes : Controller makes the input clocks; device makes echo clocks
// Notes   : All pins are one-way; no bus turnaround exists
`timescale 1ns/100ps
`default_nettype none

interface qbsr_link_if #(
    parameter int AW = qbsr_pkg::ADDR_W,
    parameter int DW = qbsr_pkg::DATA_W,
    parameter int NL = qbsr_pkg::LANES
);
    logic          k;
    logic          k_n;
    logic [AW-1:0] addr_in;
    logic          rd_n;
    logic          wr_n;
    logic [NL-1:0] lane_mask_n;
    logic [DW-1:0] d;
    logic [DW-1:0] q;
    logic          echo_timing_true;
    logic          echo_timing_comp;
    logic          dll_off_n;

    modport dev (
        input  k, k_n, addr_in, rd_n, wr_n, lane_mask_n, d, dll_off_n,
        output q, echo_timing_true, echo_timing_comp
    );

    modport ctrl (
        output k, k_n, addr_in, rd_n, wr_n, lane_mask_n, d, dll_off_n,
        input  q, echo_timing_true, echo_timing_comp
    );

endinterface

`default_nettype wire

// File: qbsr_dev.sv
// Purpose : Device end: burst-of-four static memory with split DDR ports
// Assumes : Link clocks run whenever commands are given
// Notes   : Array has no reset; rstn_i only clears pipeline state
//
// Behaviour
// - Every access moves exactly four beats
// - Separate read and write data ports
// - Read and write addresses on alternating true rises
// - Address and commands sampled on true rise
// - Write beats 1,3 true rise; 2,4 complement rise
// - Per-beat byte masks suppress single bytes
// - Controller sends first beat one cycle late
// - Write takes two cycles, buffered internally
// - Pipelined reads, late writes
// - Both edges carry read and write data
// - True and complement echo clocks with data
// - All input pins registered at the boundary
// - True rise starts access, rest self-timed
// - Loop aligns output data and echo clocks
// - No read-valid output exists
// - Write command is active low
// - Read command is active low
// - Mask low writes byte, high blocks
// - Loop disable low bypasses the loop
`timescale 1ns/100ps
`default_nettype none

module qbsr_dev #(
    parameter int AW = qbsr_pkg::ADDR_W,
    parameter int DW = qbsr_pkg::DATA_W,
    parameter int NL = qbsr_pkg::LANES
) (
    input  wire logic rstn_i,
    qbsr_link_if.dev  link
);

    localparam int LW    = DW / NL;
    localparam int WORDS = (2 ** AW) * qbsr_pkg::BURST;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [0:WORDS-1];

    // ----------------------------------------------------------------
    // True-clock state
    // ----------------------------------------------------------------
    logic          slot_reg,    slot_next;
    logic [AW-1:0] addr_reg,    addr_next;
    logic          rd_req_reg,  rd_req_next;
    logic          wr_req_reg,  wr_req_next;
    logic [DW-1:0] d_rise_reg,  d_rise_next;
    logic [NL-1:0] m_rise_reg,  m_rise_next;
    logic          wv1_reg,     wv1_next;
    logic [AW-1:0] wa1_reg,     wa1_next;
    logic          wv2_reg,     wv2_next;
    logic [AW-1:0] wa2_reg,     wa2_next;
    logic          rv1_reg,     rv1_next;
    logic [AW-1:0] ra1_reg,     ra1_next;
    logic          rv2_reg,     rv2_next;
    logic [AW-1:0] ra2_reg,     ra2_next;
    logic [DW-1:0] q_rise_reg,  q_rise_next;
    logic          doff_s1_reg;
    logic          dll_on_reg;

    // ----------------------------------------------------------------
    // Complement-clock state
    // ----------------------------------------------------------------
    logic [DW-1:0] d_fall_reg,  d_fall_next;
    logic [NL-1:0] m_fall_reg,  m_fall_next;
    logic [DW-1:0] q_fall_reg,  q_fall_next;

    // ----------------------------------------------------------------
    // Array write port, two words per true-clock edge
    // ----------------------------------------------------------------
    logic                 we;
    logic [AW+1:0]        widx0;
    logic [AW+1:0]        widx1;
    logic [DW-1:0]        wdat0;
    logic [DW-1:0]        wdat1;
    logic [NL-1:0]        wmsk0;
    logic [NL-1:0]        wmsk1;

    // ----------------------------------------------------------------
    // Input capture and command decode
    // ----------------------------------------------------------------
    always_comb begin
        slot_next   = ~slot_reg;
        addr_next   = link.addr_in;
        // Commands only count in their own slot
        rd_req_next = ~link.rd_n && (slot_reg == qbsr_pkg::SLOT_RD);
        wr_req_next = ~link.wr_n && (slot_reg == qbsr_pkg::SLOT_WR);
        d_rise_next = link.d;
        m_rise_next = link.lane_mask_n;
        // Late write: data trails the address by one cycle
        wv1_next    = wr_req_reg;
        wa1_next    = addr_reg;
        wv2_next    = wv1_reg;
        wa2_next    = wa1_reg;
        rv1_next    = rd_req_reg;
        ra1_next    = addr_reg;
        rv2_next    = rv1_reg;
        ra2_next    = ra1_reg;
    end

    // ----------------------------------------------------------------
    // Write buffer drain: beats 1,2 then beats 3,4
    // ----------------------------------------------------------------
    always_comb begin
        we    = wv1_reg || wv2_reg;
        widx0 = {wa1_reg, 2'h0};
        widx1 = {wa1_reg, 2'h1};
        wdat0 = d_rise_reg;
        wdat1 = d_fall_reg;
        wmsk0 = m_rise_reg;
        wmsk1 = m_fall_reg;
        if (wv2_reg) begin
            widx0 = {wa2_reg, 2'h2};
            widx1 = {wa2_reg, 2'h3};
        end
    end

    // ----------------------------------------------------------------
    // Read output, true edge
    // ----------------------------------------------------------------
    always_comb begin
        q_rise_next = q_rise_reg;
        if (dll_on_reg) begin
            if (rv1_reg) begin
                q_rise_next = mem[{ra1_reg, 2'h1}];
            end else if (rv2_reg) begin
                q_rise_next = mem[{ra2_reg, 2'h3}];
            end
        end else begin
            if (rd_req_reg) begin
                q_rise_next = mem[{addr_reg, 2'h0}];
            end else if (rv1_reg) begin
                q_rise_next = mem[{ra1_reg, 2'h2}];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read output and write capture, complement edge
    // ----------------------------------------------------------------
    always_comb begin
        d_fall_next = link.d;
        m_fall_next = link.lane_mask_n;
        q_fall_next = q_fall_reg;
        if (dll_on_reg) begin
            if (rv1_reg) begin
                q_fall_next = mem[{ra1_reg, 2'h0}];
            end else if (rv2_reg) begin
                q_fall_next = mem[{ra2_reg, 2'h2}];
            end
        end else begin
            if (rv1_reg) begin
                q_fall_next = mem[{ra1_reg, 2'h1}];
            end else if (rv2_reg) begin
                q_fall_next = mem[{ra2_reg, 2'h3}];
            end
        end
    end

    // ----------------------------------------------------------------
    // True-clock registers
    // ----------------------------------------------------------------
    always_ff @(posedge link.k or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_reg    <= qbsr_pkg::SLOT_RD;
            addr_reg    <= '0;
            rd_req_reg  <= 1'h0;
            wr_req_reg  <= 1'h0;
            d_rise_reg  <= '0;
            m_rise_reg  <= '1;
            wv1_reg     <= 1'h0;
            wa1_reg     <= '0;
            wv2_reg     <= 1'h0;
            wa2_reg     <= '0;
            rv1_reg     <= 1'h0;
            ra1_reg     <= '0;
            rv2_reg     <= 1'h0;
            ra2_reg     <= '0;
            q_rise_reg  <= '0;
        end else begin
            slot_reg    <= slot_next;
            addr_reg    <= addr_next;
            rd_req_reg  <= rd_req_next;
            wr_req_reg  <= wr_req_next;
            d_rise_reg  <= d_rise_next;
            m_rise_reg  <= m_rise_next;
            wv1_reg     <= wv1_next;
            wa1_reg     <= wa1_next;
            wv2_reg     <= wv2_next;
            wa2_reg     <= wa2_next;
            rv1_reg     <= rv1_next;
            ra1_reg     <= ra1_next;
            rv2_reg     <= rv2_next;
            ra2_reg     <= ra2_next;
            q_rise_reg  <= q_rise_next;
        end
    end

    // Loop disable is a static pin: two flops before use
    // Reset matches the idle pin level so the loop starts out on
    always_ff @(posedge link.k or negedge rstn_i) begin
        if (!rstn_i) begin
            doff_s1_reg <= 1'h1;
            dll_on_reg  <= 1'h1;
        end else begin
            doff_s1_reg <= link.dll_off_n;
            dll_on_reg  <= doff_s1_reg;
        end
    end

    // Array: self-timed from the true rise, masked per byte lane
    always_ff @(posedge link.k) begin
        if (we) begin
            for (int l = 0; l < NL; l++) begin
                if (!wmsk0[l]) begin
                    mem[widx0][l*LW +: LW] <= wdat0[l*LW +: LW];
                end
                if (!wmsk1[l]) begin
                    mem[widx1][l*LW +: LW] <= wdat1[l*LW +: LW];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Complement-clock registers
    // ----------------------------------------------------------------
    always_ff @(posedge link.k_n or negedge rstn_i) begin
        if (!rstn_i) begin
            d_fall_reg <= '0;
            m_fall_reg <= '1;
            q_fall_reg <= '0;
        end else begin
            d_fall_reg <= d_fall_next;
            m_fall_reg <= m_fall_next;
            q_fall_reg <= q_fall_next;
        end
    end

    // ----------------------------------------------------------------
    // Output pins; no valid flag, timing is implied by the command
    // ----------------------------------------------------------------
    // Clock-steered mux keeps each beat a full half cycle
    assign link.q = link.k ? q_rise_reg : q_fall_reg;
    assign link.echo_timing_true = link.k;
    assign link.echo_timing_comp = link.k_n;

endmodule // qbsr_dev

`default_nettype wire

// File: qbsr_ctrl.sv
// Purpose : Controller end: drives the link from system-side requests
// Assumes : Link clocks derived here, so read data is sampled on clk_sys_i
// Notes   : Change dll_off_i only while the link is idle
`timescale 1ns/100ps
`default_nettype none

module qbsr_ctrl #(
    parameter int AW = qbsr_pkg::ADDR_W,
    parameter int DW = qbsr_pkg::DATA_W,
    parameter int NL = qbsr_pkg::LANES
) (
    input  wire logic            clk_sys_i,
    input  wire logic            rstn_i,
    input  wire logic            dll_off_i,
    input  wire logic            rd_req_i,
    input  wire logic [AW-1:0]   rd_addr_i,
    output logic                 rd_ready_o,
    output logic                 rd_valid_o,
    output logic [4*DW-1:0]      rd_data_o,
    input  wire logic            wr_req_i,
    input  wire logic [AW-1:0]   wr_addr_i,
    input  wire logic [4*DW-1:0] wr_data_i,
    input  wire logic [4*NL-1:0] wr_mask_n_i,
    output logic                 wr_ready_o,
    qbsr_link_if.ctrl            link
);

    localparam int HW = qbsr_pkg::HIST_W;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0]      ph_reg,    ph_next;
    logic            k_reg,     k_next;
    logic [AW-1:0]   addr_reg,  addr_next;
    logic            rd_n_reg,  rd_n_next;
    logic            wr_n_reg,  wr_n_next;
    logic [4*DW-1:0] wbuf_reg,  wbuf_next;
    logic [4*NL-1:0] wmbuf_reg, wmbuf_next;
    logic            wpend_reg, wpend_next;
    logic [4*DW-1:0] wout_reg,  wout_next;
    logic [4*NL-1:0] wmout_reg, wmout_next;
    logic            wsend_reg, wsend_next;
    logic [DW-1:0]   d_reg,     d_next;
    logic [NL-1:0]   m_reg,     m_next;
    logic            doffn_reg, doffn_next;
    logic [HW-1:0]   hist_reg,  hist_next;
    logic [3*DW-1:0] racc_reg,  racc_next;
    logic [4*DW-1:0] rdat_reg,  rdat_next;
    logic            rval_reg,  rval_next;

    logic            rd_fire;
    logic            wr_fire;
    logic [4*DW-1:0] src_d;
    logic [4*NL-1:0] src_m;
    logic            src_v;
    logic [2:0]      cap;

    // Read slot follows phase 3, write slot follows phase 1
    assign rd_ready_o = (ph_reg == qbsr_pkg::PH_RD_PREP);
    assign wr_ready_o = (ph_reg == qbsr_pkg::PH_WR_PREP);
    assign rd_fire    = rd_req_i && rd_ready_o;
    assign wr_fire    = wr_req_i && wr_ready_o;

    // ----------------------------------------------------------------
    // Command, address and write beats
    // ----------------------------------------------------------------
    always_comb begin
        ph_next    = ph_reg + 2'h1;
        k_next     = ~ph_reg[0];
        addr_next  = addr_reg;
        rd_n_next  = ~rd_fire;
        wr_n_next  = ~wr_fire;
        wbuf_next  = wbuf_reg;
        wmbuf_next = wmbuf_reg;
        wpend_next = wpend_reg;
        wout_next  = wout_reg;
        wmout_next = wmout_reg;
        wsend_next = wsend_reg;
        doffn_next = ~dll_off_i;
        if (rd_fire) begin
            addr_next = rd_addr_i;
        end else if (wr_fire) begin
            addr_next  = wr_addr_i;
            wbuf_next  = wr_data_i;
            wmbuf_next = wr_mask_n_i;
            wpend_next = 1'h1;
        end
        // Data goes one cycle after the command
        if (ph_reg == qbsr_pkg::PH_LAST) begin
            wout_next  = wbuf_reg;
            wmout_next = wmbuf_reg;
            wsend_next = wpend_reg;
            wpend_next = 1'h0;
        end
        src_d = (ph_reg == qbsr_pkg::PH_LAST) ? wbuf_reg : wout_reg;
        src_m = (ph_reg == qbsr_pkg::PH_LAST) ? wmbuf_reg : wmout_reg;
        src_v = (ph_reg == qbsr_pkg::PH_LAST) ? wpend_reg : wsend_reg;
        d_next = src_d[ph_next*DW +: DW];
        // Idle beats carry an all-blocked mask
        m_next = src_v ? src_m[ph_next*NL +: NL] : '1;
    end

    // ----------------------------------------------------------------
    // Read return: fixed offset from the command, no valid pin
    // ----------------------------------------------------------------
    always_comb begin
        cap       = doffn_reg ? qbsr_pkg::CAP_DLL_ON
                              : qbsr_pkg::CAP_DLL_OFF;
        hist_next = {hist_reg[HW-2:0], ~rd_n_reg};
        racc_next = racc_reg;
        rdat_next = rdat_reg;
        rval_next = 1'h0;
        for (int j = 0; j < 3; j++) begin
            if (hist_reg[cap + 3'(j)]) begin
                racc_next[j*DW +: DW] = link.q;
            end
        end
        if (hist_reg[cap + 3'h3]) begin
            rdat_next = {link.q, racc_reg};
            rval_next = 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_reg    <= qbsr_pkg::PH_RESET;
            addr_reg  <= '0;
            rd_n_reg  <= 1'h1;
            wr_n_reg  <= 1'h1;
            wbuf_reg  <= '0;
            wmbuf_reg <= '1;
            wpend_reg <= 1'h0;
            wout_reg  <= '0;
            wmout_reg <= '1;
            wsend_reg <= 1'h0;
            d_reg     <= '0;
            m_reg     <= '1;
            doffn_reg <= 1'h1;
            hist_reg  <= '0;
            racc_reg  <= '0;
            rdat_reg  <= '0;
            rval_reg  <= 1'h0;
        end else begin
            ph_reg    <= ph_next;
            addr_reg  <= addr_next;
            rd_n_reg  <= rd_n_next;
            wr_n_reg  <= wr_n_next;
            wbuf_reg  <= wbuf_next;
            wmbuf_reg <= wmbuf_next;
            wpend_reg <= wpend_next;
            wout_reg  <= wout_next;
            wmout_reg <= wmout_next;
            wsend_reg <= wsend_next;
            d_reg     <= d_next;
            m_reg     <= m_next;
            doffn_reg <= doffn_next;
            hist_reg  <= hist_next;
            racc_reg  <= racc_next;
            rdat_reg  <= rdat_next;
            rval_reg  <= rval_next;
        end
    end

    // Falling-edge divider centres link edges in each data cycle
    always_ff @(negedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            k_reg <= 1'h0;
        end else begin
            k_reg <= k_next;
        end
    end

    assign link.k           = k_reg;
    assign link.k_n         = ~k_reg;
    assign link.addr_in     = addr_reg;
    assign link.rd_n        = rd_n_reg;
    assign link.wr_n        = wr_n_reg;
    assign link.d           = d_reg;
    assign link.lane_mask_n = m_reg;
    assign link.dll_off_n   = doffn_reg;
    assign rd_valid_o       = rval_reg;
    assign rd_data_o        = rdat_reg;

endmodule // qbsr_ctrl

`default_nettype wire

// File: qbsr_link_assertions.sv
// Purpose : Link-level checks between the controller and device ends
// Assumes : Link clock k is made by the controller end
// Notes   : Watches the shared interface signals only
`timescale 1ns/100ps
`default_nettype none

module qbsr_link_assertions #(
    parameter int AW = qbsr_pkg::ADDR_W,
    parameter int DW = qbsr_pkg::DATA_W,
    parameter int NL = qbsr_pkg::LANES
) (
    input wire logic          rstn_i,
    input wire logic          k,
    input wire logic          k_n,
    input wire logic [AW-1:0] addr_in,
    input wire logic          rd_n,
    input wire logic          wr_n,
    input wire logic [NL-1:0] lane_mask_n,
    input wire logic [DW-1:0] d,
    input wire logic [DW-1:0] q,
    input wire logic          echo_timing_true,
    input wire logic          echo_timing_comp,
    input wire logic          dll_off_n
);
    default clocking cb @(posedge k); endclocking
    default disable iff (!rstn_i);

    // Sampled values at an edge are those just before it
    property p_echo_rise;
        !echo_timing_true && echo_timing_comp;
    endproperty
    a_echo_rise: assert property (p_echo_rise)
        else $error("echo clocks wrong before link rise");
    property p_echo_fall;
        @(negedge k) echo_timing_true && !echo_timing_comp;
    endproperty
    a_echo_fall: assert property (p_echo_fall)
        else $error("echo clocks wrong before link fall");
    property p_comp_rise;
        k_n;
    endproperty
    a_comp_rise: assert property (p_comp_rise)
        else $error("complement clock not high before true rise");
    property p_comp_fall;
        @(negedge k) !k_n;
    endproperty
    a_comp_fall: assert property (p_comp_fall)
        else $error("complement clock not low before true fall");
    property p_rd_alt;
        !rd_n |=> rd_n;
    endproperty
    a_rd_alt: assert property (p_rd_alt)
        else $error("read command in two adjacent slots");
    property p_wr_alt;
        !wr_n |=> wr_n;
    endproperty
    a_wr_alt: assert property (p_wr_alt)
        else $error("write command in two adjacent slots");
    property p_one_cmd;
        rd_n || wr_n;
    endproperty
    a_one_cmd: assert property (p_one_cmd)
        else $error("read and write on one address edge");
    property p_dll_hold;
        !rd_n |-> $stable(dll_off_n);
    endproperty
    a_dll_hold: assert property (p_dll_hold)
        else $error("loop bypass changed with a read");
    // Beats of a write are sampled at the two rises after its command
    property p_mask_idle;
        $past(wr_n) && $past(wr_n, 2) |-> (lane_mask_n == '1);
    endproperty
    a_mask_idle: assert property (p_mask_idle)
        else $error("byte mask open with no write in flight");
    // Low-phase read beats move only two and three rises after a read
    property p_q_quiet;
        $past(rd_n, 2) && $past(rd_n, 3) |-> $stable(q);
    endproperty
    a_q_quiet: assert property (p_q_quiet)
        else $error("read data moved with no read in flight");
endmodule // qbsr_link_assertions

`default_nettype wire

// File: qbsr_bench.sv
// Purpose : Self-checking bench, controller and device joined by the link
// Assumes : Small array (AW=6) keeps the flop memory short
// Notes   : Expected bursts come from a byte-masked shadow copy
`timescale 1ns/100ps
`default_nettype none

module qbsr_bench;
    localparam int AW = 6;
    localparam int DW = qbsr_pkg::DATA_W;
    localparam int NL = qbsr_pkg::LANES;
    localparam int BW = 4 * DW;
    localparam int LW = DW / NL;
    // Edges from the taking edge to the valid pulse, loop on and off
    localparam logic [7:0] LAT_ON  = 8'h07;
    localparam logic [7:0] LAT_OFF = 8'h06;
    logic              clk_sys_i, rstn_i, dll_off_i, rd_req_i, wr_req_i;
    logic [AW-1:0]     rd_addr_i, wr_addr_i;
    logic [BW-1:0]     wr_data_i, rd_data_o;
    logic [BW-1:0]     model [2**AW];
    logic [4*NL-1:0]   wr_mask_n_i;
    logic              rd_ready_o, rd_valid_o, wr_ready_o;
    int                err_total, tests_run;

    qbsr_link_if #(.AW(AW), .DW(DW), .NL(NL)) qbsr_link_if_i ();
    qbsr_ctrl #(.AW(AW), .DW(DW), .NL(NL)) qbsr_ctrl_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .dll_off_i(dll_off_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_req_i(wr_req_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
        .wr_mask_n_i(wr_mask_n_i), .wr_ready_o(wr_ready_o),
        .link(qbsr_link_if_i));
    qbsr_dev #(.AW(AW), .DW(DW), .NL(NL)) qbsr_dev_i (
        .rstn_i(rstn_i), .link(qbsr_link_if_i));
    qbsr_link_assertions #(.AW(AW), .DW(DW), .NL(NL)) qbsr_link_assertions_i (
        .rstn_i(rstn_i), .k(qbsr_link_if_i.k), .k_n(qbsr_link_if_i.k_n),
        .addr_in(qbsr_link_if_i.addr_in), .rd_n(qbsr_link_if_i.rd_n),
        .wr_n(qbsr_link_if_i.wr_n), .lane_mask_n(qbsr_link_if_i.lane_mask_n),
        .d(qbsr_link_if_i.d), .q(qbsr_link_if_i.q),
        .echo_timing_true(qbsr_link_if_i.echo_timing_true),
        .echo_timing_comp(qbsr_link_if_i.echo_timing_comp),
        .dll_off_n(qbsr_link_if_i.dll_off_n));

    task automatic chk_burst(input logic [BW-1:0] got,
                             input logic [BW-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_lat(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Entered just after an edge; request held until the taking edge
    task automatic do_write(input logic [AW-1:0] a, input logic [BW-1:0] v,
                            input logic [4*NL-1:0] m);
        wr_addr_i = a;
        wr_data_i = v;
        wr_mask_n_i = m;
        wr_req_i = 1'h1;
        while (wr_ready_o !== 1'h1) begin
            @(posedge clk_sys_i) #1;
        end
        @(posedge clk_sys_i) #1;
        wr_req_i = 1'h0;
        // Let an edge pass so a following call never re-raises in this step
        @(posedge clk_sys_i) #1;
        for (int i = 0; i < 4 * NL; i++) begin
            if (!m[i]) model[a][i*LW +: LW] = v[i*LW +: LW];
        end
    endtask

    task automatic do_read(input logic [AW-1:0] a, input logic [7:0] lat);
        logic [7:0] n;
        n = 8'h00;
        rd_addr_i = a;
        rd_req_i = 1'h1;
        while (rd_ready_o !== 1'h1) begin
            @(posedge clk_sys_i) #1;
        end
        @(posedge clk_sys_i) #1;
        rd_req_i = 1'h0;
        while (rd_valid_o !== 1'h1 && n < 8'h20) begin
            @(posedge clk_sys_i) #1;
            n++;
        end
        chk_lat(n, lat);
        chk_burst(rd_data_o, model[a]);
    endtask

    task automatic t_plain();
        do_write(6'h00, 144'h1_2345_6780_9ABC_DEF0_1F_EDCB_A987_0246_8ACE_0,
                 16'h0000);
        do_write(6'h3F, 144'hA_AAAA_0004_5_5555_0003_C_3C3C_0002_3_C3C3_0001,
                 16'h0000);
        do_read(6'h00, LAT_ON);
        do_read(6'h3F, LAT_ON);
    endtask

    task automatic t_mask();
        do_write(6'h3F, ~model[6'h3F], 16'h5A3C);
        do_read(6'h3F, LAT_ON);
    endtask

    task automatic t_concur();
        fork
            do_write(6'h10,
                     144'h7_0F0F_0F0F_8_F0F0_F0F0_9_1111_2222_3333_4444_5,
                     16'h0000);
            do_read(6'h00, LAT_ON);
        join
        do_read(6'h10, LAT_ON);
    endtask

    task automatic t_idle();
        repeat (40) @(posedge clk_sys_i);
        #1 do_read(6'h3F, LAT_ON);
    endtask

    task automatic t_dll();
        dll_off_i = 1'h1;
        repeat (8) @(posedge clk_sys_i);
        #1 do_read(6'h10, LAT_OFF);
        dll_off_i = 1'h0;
        repeat (8) @(posedge clk_sys_i);
        #1 do_read(6'h00, LAT_ON);
    endtask

    task automatic print_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys_i = 1'h0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // Whole run is about 135 cycles
    initial begin
        #(3000 * 50);
        err_total++;
        print_verdict();
    end

    initial begin
        {rstn_i, dll_off_i, rd_req_i, wr_req_i} = 4'h0;
        {rd_addr_i, wr_addr_i, wr_data_i} = '0;
        wr_mask_n_i = '1;
        err_total = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_sys_i);
        #1 rstn_i = 1'h1;
        t_plain();
        t_mask();
        t_concur();
        t_idle();
        t_dll();
        print_verdict();
    end
endmodule // qbsr_bench

`default_nettype wire
